// file: logic/cls_map.vh
// Constants for the configuration loader and security block
`ifndef CLS_MAP_VH
`define CLS_MAP_VH
// Timing
`define CLS_CLK_PERIOD_NS 10
`define CLS_LOAD_TIME_US  100
// Test port instruction register
`define CLS_IR_W         8
`define CLS_IR_CAPTURE   8'h01
`define CLS_IR_EXTEST    8'h00
`define CLS_IR_SAMPLE    8'h01
`define CLS_IR_INTEST    8'h02
`define CLS_IR_CLAMP     8'hFA
`define CLS_IR_HIGHZ     8'hFC
`define CLS_IR_USERCODE  8'hFD
`define CLS_IR_IDCODE    8'hFE
`define CLS_IR_BYPASS    8'hFF
`define CLS_IR_PROGRAM   8'hE0
`define CLS_IR_ERASE     8'hE1
`define CLS_IR_VERIFY    8'hE2
`define CLS_IR_UNLOCK_A  8'hE3
`define CLS_IR_UNLOCK_B  8'hE4
// Security word in the nonvolatile array
`define CLS_SEC_VALID 0
`define CLS_SEC_READ  1
`define CLS_SEC_WRITE 2
// Test port controller states
`define CLS_TAP_W    4
`define CLS_TAP_TLR  4'h0
`define CLS_TAP_RTI  4'h1
`define CLS_TAP_SDR  4'h2
`define CLS_TAP_CDR  4'h3
`define CLS_TAP_SHDR 4'h4
`define CLS_TAP_E1DR 4'h5
`define CLS_TAP_PDR  4'h6
`define CLS_TAP_E2DR 4'h7
`define CLS_TAP_UDR  4'h8
`define CLS_TAP_SIR  4'h9
`define CLS_TAP_CIR  4'hA
`define CLS_TAP_SHIR 4'hB
`define CLS_TAP_E1IR 4'hC
`define CLS_TAP_PIR  4'hD
`define CLS_TAP_E2IR 4'hE
`define CLS_TAP_UIR  4'hF
`endif

// file: logic/cls_sync.v
// Two-flop synchroniser for a bundle of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module cls_sync #(
   parameter W = 1
) (
   input  wire         clk,
   input  wire         sys_rst,
   input  wire [W-1:0] din,
   output reg  [W-1:0] dout_r
);
   reg [W-1:0] meta_r;

   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         meta_r <= {W{1'b0}};
         dout_r <= {W{1'b0}};
      end
      else
      begin
         meta_r <= din;
         dout_r <= meta_r;
      end
   end
endmodule
`default_nettype wire

// file: logic/cls_top.v
// Power-up configuration loader with test port and data security
`timescale 1ns/1ps
`default_nettype none
`include "cls_map.vh"
module cls_top #(
   parameter N           = 8,
   parameter AW          = 8,
   parameter DW          = 4,
   parameter LOAD_CYCLES = (`CLS_LOAD_TIME_US * 1000) / `CLS_CLK_PERIOD_NS,
   parameter [31:0] ID_CODE   = 32'h1234_5001,
   parameter [31:0] USER_CODE = 32'hFFFF_FFFF
) (
   input  wire          clk,
   input  wire          sys_rst,
   input  wire          vcc_safe,
   input  wire          tck,
   input  wire          tms,
   input  wire          tdi,
   output reg           tdo_r,
   output reg           tdo_oe_r,
   output reg  [AW-1:0] nv_addr_r,
   input  wire [DW-1:0] nv_rdata,
   output reg  [DW-1:0] nv_wdata_r,
   output reg           nv_wr_r,
   output reg           nv_erase_r,
   output reg           latch_clr_r,
   output reg           latch_ld_r,
   output reg  [DW-1:0] latch_data_r,
   output reg           cfg_done_r,
   output reg           user_init_r,
   input  wire [N-1:0]  core_out,
   input  wire [N-1:0]  core_oe,
   input  wire [N-1:0]  pin_in,
   output reg  [N-1:0]  pin_out_r,
   output reg  [N-1:0]  pin_oe_r,
   output reg           pin_pullup_r,
   output reg  [N-1:0]  core_in_r
);
   // ID_CODE default value is arbitrary
   localparam DRW  = (N > 32) ? ((N > AW + DW) ? N : AW + DW) :
                     ((AW + DW > 32) ? AW + DW : 32);
   localparam [31:0] STEP_RAW = LOAD_CYCLES / (1 << AW);
   localparam [15:0] STEP_CYC = (STEP_RAW < 1) ? 16'h0001 :
                                STEP_RAW[15:0];
   localparam [AW-1:0] SEC_ADDR = {AW{1'b1}};
   localparam [AW-1:0] LAST_ADDR = {AW{1'b1}};
   localparam [2:0] LD_QUIET = 3'h0;
   localparam [2:0] LD_CLEAR = 3'h1;
   localparam [2:0] LD_SEC   = 3'h2;
   localparam [2:0] LD_STEP  = 3'h3;
   localparam [2:0] LD_RUN   = 3'h4;

   ////////////////////////////////////////////////////////////////////
   // Input synchronisers
   wire [N+3:0] sync_w;
   wire         vcc_s;
   wire         tck_s;
   wire         tms_s;
   wire         tdi_s;
   wire [N-1:0] pin_s;

   cls_sync #(
      .W (N + 4)
   ) u_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .din     ({vcc_safe, tck, tms, tdi, pin_in}),
      .dout_r  (sync_w)
   );

   assign vcc_s = sync_w[N+3];
   assign tck_s = sync_w[N+2];
   assign tms_s = sync_w[N+1];
   assign tdi_s = sync_w[N];
   assign pin_s = sync_w[N-1:0];

   ////////////////////////////////////////////////////////////////////
   // Decode functions
   function isp_ir;
      input [`CLS_IR_W-1:0] ir;
      begin
         isp_ir = (ir == `CLS_IR_PROGRAM) || (ir == `CLS_IR_ERASE) ||
                  (ir == `CLS_IR_VERIFY) || (ir == `CLS_IR_UNLOCK_A) ||
                  (ir == `CLS_IR_UNLOCK_B);
      end
   endfunction

   function bsr_ir;
      input [`CLS_IR_W-1:0] ir;
      begin
         bsr_ir = (ir == `CLS_IR_EXTEST) || (ir == `CLS_IR_SAMPLE) ||
                  (ir == `CLS_IR_INTEST);
      end
   endfunction

   function [7:0] dr_len;
      input [`CLS_IR_W-1:0] ir;
      begin
         if (ir == `CLS_IR_IDCODE || ir == `CLS_IR_USERCODE)
            dr_len = 8'd32;
         else if (bsr_ir(ir))
            dr_len = N[7:0];
         else if (ir == `CLS_IR_PROGRAM || ir == `CLS_IR_VERIFY)
            dr_len = AW[7:0] + DW[7:0];
         else
            dr_len = 8'd1;
      end
   endfunction

   function [`CLS_TAP_W-1:0] tap_next;
      input [`CLS_TAP_W-1:0] st;
      input                  m;
      begin
         case (st)
            `CLS_TAP_TLR:  tap_next = m ? `CLS_TAP_TLR  : `CLS_TAP_RTI;
            `CLS_TAP_RTI:  tap_next = m ? `CLS_TAP_SDR  : `CLS_TAP_RTI;
            `CLS_TAP_SDR:  tap_next = m ? `CLS_TAP_SIR  : `CLS_TAP_CDR;
            `CLS_TAP_CDR:  tap_next = m ? `CLS_TAP_E1DR : `CLS_TAP_SHDR;
            `CLS_TAP_SHDR: tap_next = m ? `CLS_TAP_E1DR : `CLS_TAP_SHDR;
            `CLS_TAP_E1DR: tap_next = m ? `CLS_TAP_UDR  : `CLS_TAP_PDR;
            `CLS_TAP_PDR:  tap_next = m ? `CLS_TAP_E2DR : `CLS_TAP_PDR;
            `CLS_TAP_E2DR: tap_next = m ? `CLS_TAP_UDR  : `CLS_TAP_SHDR;
            `CLS_TAP_UDR:  tap_next = m ? `CLS_TAP_SDR  : `CLS_TAP_RTI;
            `CLS_TAP_SIR:  tap_next = m ? `CLS_TAP_TLR  : `CLS_TAP_CIR;
            `CLS_TAP_CIR:  tap_next = m ? `CLS_TAP_E1IR : `CLS_TAP_SHIR;
            `CLS_TAP_SHIR: tap_next = m ? `CLS_TAP_E1IR : `CLS_TAP_SHIR;
            `CLS_TAP_E1IR: tap_next = m ? `CLS_TAP_UIR  : `CLS_TAP_PIR;
            `CLS_TAP_PIR:  tap_next = m ? `CLS_TAP_E2IR : `CLS_TAP_PIR;
            `CLS_TAP_E2IR: tap_next = m ? `CLS_TAP_UIR  : `CLS_TAP_SHIR;
            `CLS_TAP_UIR:  tap_next = m ? `CLS_TAP_SDR  : `CLS_TAP_RTI;
            default:       tap_next = `CLS_TAP_TLR;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Shared state
   reg  [2:0]            ld_st_r;
   reg  [AW-1:0]         ld_addr_r;
   reg  [15:0]           ld_cnt_r;
   reg                   tap_en_r;
   reg                   rd_sec_r;
   reg                   wr_sec_r;
   reg                   valid_r;
   reg                   tck_d_r;
   reg  [`CLS_TAP_W-1:0] tap_st_r;
   reg  [`CLS_IR_W-1:0]  ir_sh_r;
   reg  [`CLS_IR_W-1:0]  ir_r;
   reg  [DRW-1:0]        dr_sh_r;
   reg  [N-1:0]          bsr_upd_r;
   reg  [AW-1:0]         isc_addr_r;
   reg  [DW-1:0]         isc_data_r;
   reg                   unlock_r;
   reg                   wr_req_r;
   reg                   erase_req_r;
   reg  [DRW-1:0]        dr_cap;
   reg  [DRW-1:0]        dr_sh_nxt;
   wire                  tck_rise;
   wire                  tck_fall;
   wire                  prog_ok;
   wire                  erase_ok;
   wire [7:0]            len;

   assign tck_rise = tck_s & ~tck_d_r;
   assign tck_fall = ~tck_s & tck_d_r;
   assign prog_ok  = ~rd_sec_r & (~wr_sec_r | unlock_r);
   assign erase_ok = ~wr_sec_r | unlock_r;
   assign len      = dr_len(ir_r);

   ////////////////////////////////////////////////////////////////////
   // Loader sequence on the internal clock
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ld_st_r      <= LD_QUIET;
         ld_addr_r    <= {AW{1'b0}};
         ld_cnt_r     <= 16'h0000;
         tap_en_r     <= 1'b0;
         latch_clr_r  <= 1'b0;
         latch_ld_r   <= 1'b0;
         latch_data_r <= {DW{1'b0}};
         cfg_done_r   <= 1'b0;
         user_init_r  <= 1'b0;
      end
      else
      begin
         latch_clr_r <= 1'b0;
         latch_ld_r  <= 1'b0;
         user_init_r <= 1'b0;
         if (!vcc_s)
         begin
            ld_st_r    <= LD_QUIET;
            tap_en_r   <= 1'b0;
            cfg_done_r <= 1'b0;
         end
         else
         begin
            case (ld_st_r)
               LD_QUIET:
               begin
                  ld_st_r     <= LD_CLEAR;
                  latch_clr_r <= 1'b1;
               end
               LD_CLEAR:
               begin
                  ld_st_r   <= LD_SEC;
                  ld_addr_r <= SEC_ADDR;
               end
               LD_SEC:
               begin
                  // Array address lags by a cycle, wait for the word
                  if (nv_addr_r == SEC_ADDR)
                  begin
                     ld_st_r   <= LD_STEP;
                     tap_en_r  <= 1'b1;
                     ld_addr_r <= {AW{1'b0}};
                     ld_cnt_r  <= 16'h0000;
                  end
               end
               LD_STEP:
               begin
                  if (ld_cnt_r == STEP_CYC - 16'h0001)
                  begin
                     ld_cnt_r     <= 16'h0000;
                     latch_ld_r   <= 1'b1;
                     latch_data_r <= nv_rdata;
                     ld_addr_r    <= ld_addr_r + {{(AW-1){1'b0}}, 1'b1};
                     if (ld_addr_r == LAST_ADDR)
                        ld_st_r <= LD_RUN;
                  end
                  else
                     ld_cnt_r <= ld_cnt_r + 16'h0001;
               end
               LD_RUN:
               begin
                  if (!cfg_done_r)
                     user_init_r <= 1'b1;
                  cfg_done_r <= 1'b1;
               end
               default:
                  ld_st_r <= LD_QUIET;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Array port: address from the loader until LD_RUN, then from the test port; write data and strobes always from the test port
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         nv_addr_r  <= {AW{1'b0}};
         nv_wdata_r <= {DW{1'b0}};
         nv_wr_r    <= 1'b0;
         nv_erase_r <= 1'b0;
      end
      else
      begin
         nv_addr_r  <= (ld_st_r == LD_RUN) ? isc_addr_r : ld_addr_r;
         nv_wdata_r <= isc_data_r;
         nv_wr_r    <= wr_req_r;
         nv_erase_r <= erase_req_r;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Security bits
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rd_sec_r <= 1'b0;
         wr_sec_r <= 1'b0;
         valid_r  <= 1'b0;
      end
      else if (ld_st_r == LD_SEC && nv_addr_r == SEC_ADDR)
      begin
         rd_sec_r <= nv_rdata[`CLS_SEC_READ];
         wr_sec_r <= nv_rdata[`CLS_SEC_WRITE];
         valid_r  <= nv_rdata[`CLS_SEC_VALID];
      end
      else if (erase_req_r)
      begin
         rd_sec_r <= 1'b0;
         wr_sec_r <= 1'b0;
         valid_r  <= 1'b0;
      end
      else if (wr_req_r && isc_addr_r == SEC_ADDR)
      begin
         rd_sec_r <= rd_sec_r | isc_data_r[`CLS_SEC_READ];
         wr_sec_r <= wr_sec_r | isc_data_r[`CLS_SEC_WRITE];
         valid_r  <= valid_r | isc_data_r[`CLS_SEC_VALID];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Data register capture and shift
   always @*
   begin
      dr_cap = {DRW{1'b0}};
      if (ir_r == `CLS_IR_IDCODE)
         dr_cap[31:0] = ID_CODE;
      else if (ir_r == `CLS_IR_USERCODE)
         dr_cap[31:0] = USER_CODE;
      else if (bsr_ir(ir_r))
         dr_cap[N-1:0] = pin_s;
      else if (ir_r == `CLS_IR_VERIFY)
      begin
         dr_cap[AW+DW-1:DW] = isc_addr_r;
         if (!rd_sec_r)
            dr_cap[DW-1:0] = nv_rdata;
      end
   end

   always @*
   begin
      dr_sh_nxt = dr_sh_r >> 1;
      dr_sh_nxt[len-1] = tdi_s;
   end

   ////////////////////////////////////////////////////////////////////
   // Test access port
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         tck_d_r     <= 1'b0;
         tap_st_r    <= `CLS_TAP_TLR;
         ir_sh_r     <= {`CLS_IR_W{1'b0}};
         ir_r        <= `CLS_IR_IDCODE;
         dr_sh_r     <= {DRW{1'b0}};
         bsr_upd_r   <= {N{1'b0}};
         isc_addr_r  <= {AW{1'b0}};
         isc_data_r  <= {DW{1'b0}};
         unlock_r    <= 1'b0;
         wr_req_r    <= 1'b0;
         erase_req_r <= 1'b0;
         tdo_r       <= 1'b0;
         tdo_oe_r    <= 1'b0;
      end
      else
      begin
         tck_d_r     <= tck_s;
         wr_req_r    <= 1'b0;
         erase_req_r <= 1'b0;
         if (!tap_en_r)
         begin
            tap_st_r <= `CLS_TAP_TLR;
            ir_r     <= `CLS_IR_IDCODE;
            unlock_r <= 1'b0;
            tdo_oe_r <= 1'b0;
         end
         else if (tck_rise)
         begin
            tap_st_r <= tap_next(tap_st_r, tms_s);
            case (tap_st_r)
               `CLS_TAP_TLR:
               begin
                  ir_r     <= `CLS_IR_IDCODE;
                  unlock_r <= 1'b0;
               end
               `CLS_TAP_CDR:
                  dr_sh_r <= dr_cap;
               `CLS_TAP_SHDR:
                  dr_sh_r <= dr_sh_nxt;
               `CLS_TAP_UDR:
               begin
                  if (bsr_ir(ir_r) || ir_r == `CLS_IR_CLAMP)
                     bsr_upd_r <= dr_sh_r[N-1:0];
                  if (ir_r == `CLS_IR_PROGRAM || ir_r == `CLS_IR_VERIFY)
                     isc_addr_r <= dr_sh_r[AW+DW-1:DW];
                  if (ir_r == `CLS_IR_PROGRAM)
                  begin
                     isc_data_r <= dr_sh_r[DW-1:0];
                     wr_req_r   <= prog_ok;
                  end
                  if (ir_r == `CLS_IR_ERASE)
                     erase_req_r <= erase_ok;
               end
               `CLS_TAP_CIR:
                  ir_sh_r <= `CLS_IR_CAPTURE;
               `CLS_TAP_SHIR:
                  ir_sh_r <= {tdi_s, ir_sh_r[`CLS_IR_W-1:1]};
               `CLS_TAP_UIR:
               begin
                  ir_r <= ir_sh_r;
                  if (ir_sh_r == `CLS_IR_UNLOCK_B &&
                      ir_r == `CLS_IR_UNLOCK_A)
                     unlock_r <= 1'b1;
               end
               default:
                  ir_r <= ir_r;
            endcase
         end
         else if (tck_fall)
         begin
            tdo_r    <= (tap_st_r == `CLS_TAP_SHIR) ? ir_sh_r[0] :
                        dr_sh_r[0];
            tdo_oe_r <= (tap_st_r == `CLS_TAP_SHIR) ||
                        (tap_st_r == `CLS_TAP_SHDR);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // User pins
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pin_out_r    <= {N{1'b0}};
         pin_oe_r     <= {N{1'b0}};
         pin_pullup_r <= 1'b1;
         core_in_r    <= {N{1'b0}};
      end
      else if (ir_r == `CLS_IR_EXTEST || ir_r == `CLS_IR_CLAMP)
      begin
         pin_out_r    <= bsr_upd_r;
         pin_oe_r     <= {N{1'b1}};
         pin_pullup_r <= 1'b0;
         core_in_r    <= {N{1'b0}};
      end
      else if (!cfg_done_r || !valid_r || isp_ir(ir_r) ||
               ir_r == `CLS_IR_INTEST || ir_r == `CLS_IR_HIGHZ)
      begin
         pin_out_r    <= {N{1'b0}};
         pin_oe_r     <= {N{1'b0}};
         pin_pullup_r <= 1'b1;
         core_in_r    <= {N{1'b0}};
      end
      else
      begin
         pin_out_r    <= core_out;
         pin_oe_r     <= core_oe;
         pin_pullup_r <= 1'b0;
         core_in_r    <= pin_s;
      end
   end
endmodule
`default_nettype wire

// file: tb/cls_top_sva.sv
// Checker for the configuration loader and security block
`timescale 1ns/1ps
`default_nettype none
module cls_top_sva #(
   parameter N           = 8,
   parameter AW          = 8,
   parameter LOAD_CYCLES = 10000
) (
   input wire logic         clk,
   input wire logic         sys_rst,
   input wire logic         vcc_safe,
   input wire logic         nv_wr_r,
   input wire logic         nv_erase_r,
   input wire logic         latch_clr_r,
   input wire logic         latch_ld_r,
   input wire logic         cfg_done_r,
   input wire logic         user_init_r,
   input wire logic [N-1:0] pin_oe_r,
   input wire logic         pin_pullup_r
);
   localparam int STEP = LOAD_CYCLES / (1 << AW);
   logic [15:0] ld_cnt_r;
   logic [15:0] gap_r;
   logic [15:0] tot_r;
   ////////////////////////////////////////////////////////////////////////////
   // Strobe count, strobe spacing and load length since the latch clear
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ld_cnt_r <= 16'h0000;
         gap_r    <= 16'h0000;
         tot_r    <= 16'h0000;
      end
      else
      begin
         ld_cnt_r <= latch_clr_r ? 16'h0000 :
                     ld_cnt_r + {15'h0000, latch_ld_r};
         gap_r    <= latch_ld_r ? 16'h0001 : gap_r + 16'h0001;
         tot_r    <= latch_clr_r ? 16'h0001 : tot_r + 16'h0001;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_quiet;
      !vcc_safe [*6];
   endsequence
   sequence s_done_rise;
      $rose(cfg_done_r);
   endsequence
   sequence s_init_pulse;
      user_init_r ##1 !user_init_r;
   endsequence
   quiet_hold_a: assert property (
      s_quiet |-> !cfg_done_r && !latch_ld_r) else $error("load while low");
   pins_off_a: assert property (
      !cfg_done_r [*2] |-> pin_oe_r == '0 && pin_pullup_r)
      else $error("pins on before done");
   done_last_a: assert property (
      s_done_rise |-> ld_cnt_r == (1 << AW)) else $error("early done");
   strobe_gap_a: assert property (
      latch_ld_r && ld_cnt_r != 16'h0000 |-> gap_r == STEP)
      else $error("strobe spacing");
   load_time_a: assert property (
      s_done_rise |-> tot_r >= LOAD_CYCLES / 2 && tot_r <= LOAD_CYCLES + 64)
      else $error("load length");
   init_after_a: assert property (
      s_done_rise |-> s_init_pulse) else $error("no init pulse");
   load_start_a: assert property (
      $rose(vcc_safe) && !cfg_done_r |-> ##[1:8] latch_clr_r)
      else $error("no latch clear");
   isp_float_a: assert property (
      nv_wr_r || nv_erase_r |-> pin_oe_r == '0 && pin_pullup_r)
      else $error("pins driven in isp");
endmodule
`default_nettype wire

// file: tb/cls_prog.sv
// Boundary-scan programmer model for the test port
`timescale 1ns/1ps
`default_nettype none
module cls_prog (
   output var logic tck,
   output var logic tms,
   output var logic tdi,
   input  wire logic tdo
);
   // Clock stands low between frames, data input idles at its pull-up
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end
   task automatic pulse(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #80;
      o = tdo;
      tck = 1'b1;
      #80;
      tck = 1'b0;
   endtask
   task automatic reset_tap;
      logic o;
      repeat (5) pulse(1'b1, 1'b1, o);
      pulse(1'b0, 1'b1, o);
   endtask
   // Idle to idle scan, first bit first
   task automatic scan(input logic ir, input logic [31:0] din, input int len,
                       output logic [31:0] dout);
      logic o;
      dout = 32'h0;
      pulse(1'b1, 1'b1, o);
      if (ir)
         pulse(1'b1, 1'b1, o);
      pulse(1'b0, 1'b1, o);
      pulse(1'b0, 1'b1, o);
      for (int i = 0; i < len; i++)
         pulse(i == len - 1, din[i], dout[i]);
      pulse(1'b1, 1'b1, o);
      pulse(1'b0, 1'b1, o);
      tdi = 1'b1;
   endtask
endmodule
`default_nettype wire

// file: tb/cls_tb.sv
// Self-checking bench for the configuration loader and security block
`timescale 1ns/1ps
`default_nettype none
`include "cls_map.vh"
module tb;
   localparam int          LC  = 512;
   localparam logic [31:0] IDC = 32'hA5C3_0F01; // Arbitrary identity value
   logic        clk, sys_rst, vcc_safe, tck, tms, tdi, tdo_r, tdo_oe_r;
   logic [7:0]  nv_addr_r, core_out, core_oe, pin_in, pin_out_r, pin_oe_r;
   logic [7:0]  core_in_r, prev_addr;
   logic [3:0]  nv_rdata, nv_wdata_r, latch_data_r;
   logic        nv_wr_r, nv_erase_r, latch_clr_r, latch_ld_r;
   logic        cfg_done_r, user_init_r, pin_pullup_r;
   logic [3:0]  mem [0:255];
   logic [31:0] rd;
   int          n_errors = 0, checks = 0, cyc = 0;
   int          n_wr = 0, n_er = 0, n_ld = 0, n_clr = 0, n_init = 0;
   cls_top #(.LOAD_CYCLES(LC), .ID_CODE(IDC)) DUT (
      .clk(clk), .sys_rst(sys_rst), .vcc_safe(vcc_safe), .tck(tck),
      .tms(tms), .tdi(tdi), .tdo_r(tdo_r), .tdo_oe_r(tdo_oe_r),
      .nv_addr_r(nv_addr_r), .nv_rdata(nv_rdata), .nv_wdata_r(nv_wdata_r),
      .nv_wr_r(nv_wr_r), .nv_erase_r(nv_erase_r), .latch_clr_r(latch_clr_r),
      .latch_ld_r(latch_ld_r), .latch_data_r(latch_data_r),
      .cfg_done_r(cfg_done_r), .user_init_r(user_init_r),
      .core_out(core_out), .core_oe(core_oe), .pin_in(pin_in),
      .pin_out_r(pin_out_r), .pin_oe_r(pin_oe_r),
      .pin_pullup_r(pin_pullup_r), .core_in_r(core_in_r));
   cls_prog prog (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_r));
   assign nv_rdata = mem[nv_addr_r];
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input string what, input logic [31:0] exp, seen);
      checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Nonvolatile array model, pulse counters and timeout
   always @(posedge clk)
   begin
      prev_addr <= nv_addr_r;
      cyc <= cyc + 1;
      n_wr <= n_wr + nv_wr_r;
      n_er <= n_er + nv_erase_r;
      n_ld <= n_ld + latch_ld_r;
      n_clr <= n_clr + latch_clr_r;
      n_init <= n_init + user_init_r;
      if (nv_wr_r)
         mem[nv_addr_r] <= nv_wdata_r;
      if (nv_erase_r)
         foreach (mem[i]) mem[i] <= 4'h0;
      if (latch_ld_r)
         check("latch data", mem[prev_addr], latch_data_r);
      if (cyc == 90000)
      begin
         n_errors++;
         wrap_up();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic power(input logic [3:0] sec);
      int ld0, clr0, ini0;
      vcc_safe = 1'b0;
      tick(10);
      mem[8'hFF] = sec;
      ld0 = n_ld;
      clr0 = n_clr;
      ini0 = n_init;
      vcc_safe = 1'b1;
      for (int i = 0; i < 2000 && cfg_done_r !== 1'b1; i++)
         tick(1);
      tick(3);
      check("done", 1'b1, cfg_done_r);
      check("clears", 1, n_clr - clr0);
      check("strobes", 256, n_ld - ld0);
      check("init", 1, n_init - ini0);
      check("pullup", !sec[0], pin_pullup_r);
      prog.reset_tap();
   endtask
   task automatic op(input logic [7:0] code, input logic [11:0] dr);
      prog.scan(1'b1, {24'h0, code}, 8, rd);
      prog.scan(1'b0, {20'h0, dr}, 12, rd);
      tick(4);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_quiet;
      tick(20);
      check("quiet oe", 8'h00, pin_oe_r);
      check("quiet pullup", 1'b1, pin_pullup_r);
      check("quiet clears", 0, n_clr);
   endtask
   task automatic t_erased;
      logic [7:0]  code [3] = '{`CLS_IR_IDCODE, `CLS_IR_USERCODE,
                                `CLS_IR_BYPASS};
      logic [31:0] exp [3] = '{IDC, 32'hFFFF_FFFF, 32'h0};
      int          len [3] = '{32, 32, 1};
      power(4'h0);
      check("erased oe", 8'h00, pin_oe_r);
      for (int i = 0; i < 3; i++)
      begin
         prog.scan(1'b1, {24'h0, code[i]}, 8, rd);
         check("ir capture", 8'h01, rd[7:0]);
         prog.scan(1'b0, 32'h0, len[i], rd);
         check("dr capture", exp[i], rd);
      end
      check("tdo idle", 1'b0, tdo_oe_r);
   endtask
   task automatic t_valid;
      power(4'h1);
      core_oe = 8'h5A;
      core_out = 8'h3C;
      pin_in = 8'hC3;
      tick(8);
      check("pin oe", 8'h5A, pin_oe_r);
      check("pin out", 8'h3C, pin_out_r);
      check("core in", 8'hC3, core_in_r);
      op(`CLS_IR_PROGRAM, {8'h10, 4'h9});
      check("isp float", 8'h00, pin_oe_r);
      check("program", 4'h9, mem[8'h10]);
   endtask
   task automatic t_table;
      logic [3:0] sec [4] = '{4'h1, 4'h5, 4'h3, 4'h7};
      int         w0;
      for (int i = 0; i < 4; i++)
      begin
         mem[8'h40] = 4'h6;
         power(sec[i]);
         op(`CLS_IR_VERIFY, {8'h40, 4'h0});
         prog.scan(1'b0, {20'h0, 8'h40, 4'h0}, 12, rd);
         check("readback", sec[i][1] ? 4'h0 : 4'h6, rd[3:0]);
         w0 = n_wr;
         op(`CLS_IR_PROGRAM, {8'h41, 4'h2});
         check("gate", sec[i][2:1] == 2'h0, n_wr - w0);
      end
   endtask
   task automatic t_unlock;
      int e0;
      power(4'h5);
      e0 = n_er;
      op(`CLS_IR_ERASE, 12'h000);
      check("erase locked", 0, n_er - e0);
      prog.scan(1'b1, {24'h0, `CLS_IR_UNLOCK_A}, 8, rd);
      prog.scan(1'b1, {24'h0, `CLS_IR_UNLOCK_B}, 8, rd);
      op(`CLS_IR_ERASE, 12'h000);
      check("erase unlocked", 1, n_er - e0);
   endtask
   task automatic t_rsec_erase;
      int e0, w0;
      power(4'h3);
      e0 = n_er;
      w0 = n_wr;
      op(`CLS_IR_ERASE, 12'h000);
      check("erase allowed", 1, n_er - e0);
      op(`CLS_IR_PROGRAM, {8'h41, 4'h2});
      check("prog after erase", 1, n_wr - w0);
   endtask
   initial
   begin
      sys_rst = 1'b1;
      vcc_safe = 1'b0;
      core_out = 8'h00;
      core_oe = 8'h00;
      pin_in = 8'h00;
      foreach (mem[i]) mem[i] = 4'h0;
      tick(6);
      sys_rst = 1'b0;
      t_quiet();
      t_erased();
      t_valid();
      t_table();
      t_unlock();
      t_rsec_erase();
      wrap_up();
   end
endmodule
bind cls_top cls_top_sva #(.N(N), .AW(AW), .LOAD_CYCLES(LOAD_CYCLES)) u_sva (
   .clk(clk), .sys_rst(sys_rst), .vcc_safe(vcc_safe), .nv_wr_r(nv_wr_r),
   .nv_erase_r(nv_erase_r), .latch_clr_r(latch_clr_r),
   .latch_ld_r(latch_ld_r), .cfg_done_r(cfg_done_r),
   .user_init_r(user_init_r), .pin_oe_r(pin_oe_r),
   .pin_pullup_r(pin_pullup_r));
`default_nettype wire
